// ---- hw/tsg_ctrl.sv ----
// Ground-start trunk line controller with an APB register slave
//
// Contract
// - Idle holds bias control high
// - Originate by driving ring-ground control low
// - Wait for tip ground detect low
// - Then drive seize control high
// - Then drive bias control low
// - Finally ring-ground control high; link up
// - Tip or ring ground means incoming
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps

module tsg_ctrl
  import tsg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trunk interface detect outputs (active low, asynchronous)
  input wire logic ringing_detect_n,
  input wire logic forward_loop_detect_n,
  input wire logic reverse_loop_detect_n,
  input wire logic tip_ground_detect_n,
  input wire logic ring_ground_detect_n,
  // Trunk interface control inputs
  output logic line_seize_ctrl,
  output logic bias_relay_ctrl,
  output logic ring_ground_ctrl,
  output logic balance_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [4:0] det_meta_q; // First synchroniser stage
  logic [4:0] det_sync_q; // Second stage, active low
  logic [5:0] ctrl_q; // Control register
  logic [2:0] evt_q; // Sticky events
  logic [15:0] tmo_ms_q; // Tip-ground wait limit
  tsg_state_t state_q; // Sequencer state
  tsg_state_t state_d; // Next state
  logic [16:0] tick_cnt_q; // Millisecond divider
  logic ms_tick; // One-cycle millisecond enable
  logic [15:0] wait_ms_q; // Elapsed wait in ms
  logic wr_en; // Write strobe in access phase
  logic [2:0] evt_set; // Event set pulses
  logic tip_gnd; // Tip grounded, synchronised
  logic ring_gnd; // Ring grounded, synchronised

  // Address decode, used by reads and writes
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Detect synchronisers

  // Two flops per asynchronous detect line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      det_meta_q <= 5'h1f;
      det_sync_q <= 5'h1f;
    end
    else
    begin
      det_meta_q <= {ring_ground_detect_n, tip_ground_detect_n, reverse_loop_detect_n,
                     forward_loop_detect_n, ringing_detect_n};
      det_sync_q <= det_meta_q;
    end
  end

  // Ground detects are active low
  assign tip_gnd = ~det_sync_q[3];
  assign ring_gnd = ~det_sync_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Zero-wait slave; every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;

  // Control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= TSG_CTRL_RST;
    end
    else if (wr_en && addr_hit(paddr, TSG_CTRL_OFS))
    begin
      ctrl_q <= pwdata[5:0];
    end
    else
    begin
      // Originate and release are self-clearing commands
      ctrl_q[TSG_CTRL_ORIG_BIT] <= 1'b0;
      ctrl_q[TSG_CTRL_RELEASE_BIT] <= 1'b0;
    end
  end

  // Timeout register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmo_ms_q <= TSG_TMO_MS_RST;
    end
    else if (wr_en && addr_hit(paddr, TSG_TMO_OFS))
    begin
      tmo_ms_q <= pwdata[15:0];
    end
  end

  // Sticky events, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_q <= TSG_EVT_RST;
    end
    else if (wr_en && addr_hit(paddr, TSG_EVT_OFS))
    begin
      evt_q <= (evt_q & ~pwdata[2:0]) | evt_set;
    end
    else
    begin
      evt_q <= evt_q | evt_set;
    end
  end

  // Read data register, loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      if (addr_hit(paddr, TSG_CTRL_OFS))
        prdata <= {26'h000_0000, ctrl_q};
      else if (addr_hit(paddr, TSG_STAT_OFS))
        prdata <= {21'h00_0000, state_q, 3'h0, ~det_sync_q};
      else if (addr_hit(paddr, TSG_EVT_OFS))
        prdata <= {29'h0000_0000, evt_q};
      else if (addr_hit(paddr, TSG_TMO_OFS))
        prdata <= {16'h0000, tmo_ms_q};
      else
        prdata <= 32'h0000_0000; // Unmapped reads as zero
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond divider and wait counter

  // One-cycle enable every millisecond
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_q <= 17'h0_0000;
    else if (ms_tick)
      tick_cnt_q <= 17'h0_0000;
    else
      tick_cnt_q <= tick_cnt_q + 17'h0_0001;
  end

  assign ms_tick = (tick_cnt_q == 17'(TSG_MS_CYCLES - 1));

  // Elapsed time while waiting for tip ground
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_ms_q <= 16'h0000;
    else if (state_q != TSG_GROUND_RING)
      wait_ms_q <= 16'h0000;
    else if (ms_tick && wait_ms_q != 16'hffff)
      wait_ms_q <= wait_ms_q + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ground-start sequencer

  // Next-state logic, one step per cycle
  always_comb
  begin
    state_d = state_q;
    evt_set = 3'h0;
    case (state_q)
      TSG_IDLE:
      begin
        if (ctrl_q[TSG_CTRL_GS_EN_BIT] && (tip_gnd || ring_gnd))
        begin
          state_d = TSG_INCOMING;
          evt_set[TSG_EVT_INCOMING_BIT] = 1'b1;
        end
        else if (ctrl_q[TSG_CTRL_GS_EN_BIT] && ctrl_q[TSG_CTRL_ORIG_BIT])
          state_d = TSG_GROUND_RING;
      end
      TSG_GROUND_RING:
      begin
        if (tip_gnd)
          state_d = TSG_SEIZE;
        else if (ctrl_q[TSG_CTRL_RELEASE_BIT])
          state_d = TSG_IDLE;
        else if (wait_ms_q >= tmo_ms_q)
        begin
          state_d = TSG_IDLE;
          evt_set[TSG_EVT_TIMEOUT_BIT] = 1'b1;
        end
      end
      TSG_SEIZE: state_d = TSG_DROP_BIAS;
      TSG_DROP_BIAS: state_d = TSG_LIFT_RING;
      TSG_LIFT_RING:
      begin
        state_d = TSG_LINK;
        evt_set[TSG_EVT_LINK_BIT] = 1'b1;
      end
      TSG_INCOMING:
      begin
        if (ctrl_q[TSG_CTRL_ANSWER_BIT])
        begin
          state_d = TSG_LINK;
          evt_set[TSG_EVT_LINK_BIT] = 1'b1;
        end
        else if (ctrl_q[TSG_CTRL_RELEASE_BIT] || !(tip_gnd || ring_gnd))
          state_d = TSG_IDLE;
      end
      TSG_LINK:
      begin
        if (ctrl_q[TSG_CTRL_RELEASE_BIT] || !ctrl_q[TSG_CTRL_GS_EN_BIT])
          state_d = TSG_IDLE;
      end
      default: state_d = TSG_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= TSG_IDLE;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trunk control outputs, registered

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_seize_ctrl <= 1'b0;
      bias_relay_ctrl <= 1'b1;
      ring_ground_ctrl <= 1'b1;
      balance_select <= 1'b0;
    end
    else
    begin
      balance_select <= ctrl_q[TSG_CTRL_BAL_BIT];
      case (state_d)
        TSG_IDLE:
        begin
          // Loop-start mode may pulse the seize line directly
          line_seize_ctrl <= !ctrl_q[TSG_CTRL_GS_EN_BIT] && ctrl_q[TSG_CTRL_PULSE_BIT];
          bias_relay_ctrl <= 1'b1;
          ring_ground_ctrl <= 1'b1;
        end
        TSG_GROUND_RING:
        begin
          line_seize_ctrl <= 1'b0;
          bias_relay_ctrl <= 1'b1;
          ring_ground_ctrl <= 1'b0;
        end
        TSG_SEIZE:
        begin
          line_seize_ctrl <= 1'b1;
          bias_relay_ctrl <= 1'b1;
          ring_ground_ctrl <= 1'b0;
        end
        TSG_DROP_BIAS:
        begin
          line_seize_ctrl <= 1'b1;
          bias_relay_ctrl <= 1'b0;
          ring_ground_ctrl <= 1'b0;
        end
        TSG_INCOMING:
        begin
          line_seize_ctrl <= 1'b0;
          bias_relay_ctrl <= 1'b1;
          ring_ground_ctrl <= 1'b1;
        end
        default:
        begin
          // Lift ring and link: seized, bias off, ring ground removed
          line_seize_ctrl <= 1'b1;
          bias_relay_ctrl <= 1'b0;
          ring_ground_ctrl <= 1'b1;
        end
      endcase
    end
  end

endmodule : tsg_ctrl

// ---- shared/tsg_pkg.sv ----
// Package for the ground-start trunk line controller
package tsg_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [11:0] TSG_CTRL_OFS = 12'h000;
  localparam logic [11:0] TSG_STAT_OFS = 12'h004;
  localparam logic [11:0] TSG_EVT_OFS = 12'h008;
  localparam logic [11:0] TSG_TMO_OFS = 12'h00c;

  // Control register fields
  localparam int TSG_CTRL_ORIG_BIT = 0;
  localparam int TSG_CTRL_RELEASE_BIT = 1;
  localparam int TSG_CTRL_GS_EN_BIT = 2;
  localparam int TSG_CTRL_BAL_BIT = 3;
  localparam int TSG_CTRL_ANSWER_BIT = 4;
  localparam int TSG_CTRL_PULSE_BIT = 5;
  localparam logic [5:0] TSG_CTRL_RST = 6'h00;

  // Status register fields
  localparam int TSG_STAT_RING_BIT = 0;
  localparam int TSG_STAT_FWD_BIT = 1;
  localparam int TSG_STAT_REV_BIT = 2;
  localparam int TSG_STAT_TIPG_BIT = 3;
  localparam int TSG_STAT_RINGG_BIT = 4;
  localparam int TSG_STAT_STATE_LSB = 8;

  // Event register fields (sticky, write one to clear)
  localparam int TSG_EVT_LINK_BIT = 0;
  localparam int TSG_EVT_INCOMING_BIT = 1;
  localparam int TSG_EVT_TIMEOUT_BIT = 2;
  localparam logic [2:0] TSG_EVT_RST = 3'h0;

  // Tip-ground wait limit, in milliseconds
  localparam logic [15:0] TSG_TMO_MS_RST = 16'h1388;
  // Clock rate and one millisecond tick
  localparam int TSG_CLK_HZ = 125000000;
  localparam int TSG_MS_CYCLES = TSG_CLK_HZ / 1000;

  // Controller states, Gray coded along the originating path
  typedef enum logic [2:0] {
    TSG_IDLE = 3'b000,
    TSG_GROUND_RING = 3'b001,
    TSG_SEIZE = 3'b011,
    TSG_DROP_BIAS = 3'b010,
    TSG_LIFT_RING = 3'b110,
    TSG_LINK = 3'b111,
    TSG_INCOMING = 3'b101
  } tsg_state_t;

endpackage : tsg_pkg

// ---- testbench/tb_tsg_ctrl.sv ----
// Register-level bench for the ground-start controller
`timescale 1ns/100ps
module tb_tsg_ctrl;
  import tsg_pkg::*;
  localparam int RDLY = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ringing_detect_n, forward_loop_detect_n, reverse_loop_detect_n, tip_ground_detect_n, ring_ground_detect_n;
  logic line_seize_ctrl, bias_relay_ctrl, ring_ground_ctrl, balance_select;
  logic co_answer, co_ring_gnd, co_ringing, co_batt, co_rev;
  int n_errors = 0;
  int checks_done = 0;
  tsg_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ringing_detect_n(ringing_detect_n),
    .forward_loop_detect_n(forward_loop_detect_n), .reverse_loop_detect_n(reverse_loop_detect_n),
    .tip_ground_detect_n(tip_ground_detect_n), .ring_ground_detect_n(ring_ground_detect_n),
    .line_seize_ctrl(line_seize_ctrl), .bias_relay_ctrl(bias_relay_ctrl), .ring_ground_ctrl(ring_ground_ctrl),
    .balance_select(balance_select));
  tsg_trunk_model #(.RING_DLY(RDLY)) u_line (.pclk(pclk), .line_seize_ctrl(line_seize_ctrl),
    .bias_relay_ctrl(bias_relay_ctrl), .ring_ground_ctrl(ring_ground_ctrl), .co_answer(co_answer),
    .co_ring_gnd(co_ring_gnd), .co_ringing(co_ringing), .co_batt(co_batt), .co_rev(co_rev),
    .ringing_detect_n(ringing_detect_n), .forward_loop_detect_n(forward_loop_detect_n),
    .reverse_loop_detect_n(reverse_loop_detect_n), .tip_ground_detect_n(tip_ground_detect_n),
    .ring_ground_detect_n(ring_ground_detect_n));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = !pclk;
  end
  ////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      end_sim();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  task rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
    chk("pslverr", 32'h0, {31'h0, pslverr});
  endtask : rdchk
  // Poll the state code with a bounded count
  task wait_state(input logic [2:0] s);
    for (int k = 0; k < 60; k++)
    begin
      apb(1'b0, TSG_STAT_OFS, 32'h0);
      if (rd[10:8] === s)
        break;
    end
    chk("state", {29'h0, s}, {29'h0, rd[10:8]});
    if (rd[10:8] !== s)
      end_sim();
  endtask : wait_state
  task pins(input logic [3:0] e, input string nm);
    chk(nm, {28'h0, e}, {28'h0, line_seize_ctrl, bias_relay_ctrl, ring_ground_ctrl, balance_select});
  endtask : pins
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {co_answer, co_ring_gnd, co_ringing, co_rev} = '0;
    co_batt = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    pins(4'h6, "reset pins");
    rdchk(TSG_TMO_OFS, 32'hffff, 32'h1388, "timeout reg");
    rdchk(TSG_CTRL_OFS, 32'h3f, 32'h0, "ctrl reg");
    rdchk(12'h010, 32'hffffffff, 32'h0, "unmapped");
    rdchk(TSG_STAT_OFS, 32'h6, 32'h2, "forward loop");
    co_rev <= 1'b1;
    // Let the change cross the synchroniser before the status is latched
    repeat (2) @(posedge pclk);
    rdchk(TSG_STAT_OFS, 32'h6, 32'h4, "reverse loop");
    co_ringing <= 1'b1;
    repeat (RDLY + 4) @(posedge pclk);
    rdchk(TSG_STAT_OFS, 32'h1, 32'h1, "ringing on");
    co_ringing <= 1'b0;
    repeat (RDLY + 4) @(posedge pclk);
    rdchk(TSG_STAT_OFS, 32'h1, 32'h0, "ringing off");
    co_answer <= 1'b1;
    apb(1'b1, TSG_CTRL_OFS, 32'h5);
    wait_state(TSG_LINK);
    pins(4'ha, "link pins");
    rdchk(TSG_STAT_OFS, 32'h18, 32'h08, "tip ground");
    rdchk(TSG_EVT_OFS, 32'h7, 32'h1, "link event");
    apb(1'b1, TSG_EVT_OFS, 32'h1);
    rdchk(TSG_EVT_OFS, 32'h7, 32'h0, "event clear");
    apb(1'b1, TSG_CTRL_OFS, 32'h6);
    // Office lifts tip a few cycles after release; let detects settle
    repeat (8) @(posedge pclk);
    wait_state(TSG_IDLE);
    pins(4'h6, "release pins");
    co_answer <= 1'b0;
    // Zero wait limit: originate with no office answer times out at once
    apb(1'b1, TSG_TMO_OFS, 32'h0);
    apb(1'b1, TSG_CTRL_OFS, 32'h5);
    repeat (8) @(posedge pclk);
    wait_state(TSG_IDLE);
    pins(4'h6, "timeout pins");
    rdchk(TSG_EVT_OFS, 32'h4, 32'h4, "timeout event");
    apb(1'b1, TSG_EVT_OFS, 32'h7);
    rdchk(TSG_EVT_OFS, 32'h7, 32'h0, "events idle");
    co_ring_gnd <= 1'b1;
    wait_state(TSG_INCOMING);
    rdchk(TSG_STAT_OFS, 32'h18, 32'h10, "ring ground");
    rdchk(TSG_EVT_OFS, 32'h2, 32'h2, "incoming event");
    apb(1'b1, TSG_CTRL_OFS, 32'h14);
    wait_state(TSG_LINK);
    pins(4'ha, "answer pins");
    co_ring_gnd <= 1'b0;
    apb(1'b1, TSG_CTRL_OFS, 32'h6);
    wait_state(TSG_IDLE);
    apb(1'b1, TSG_CTRL_OFS, 32'hc);
    // Pins follow the control register one cycle later
    repeat (2) @(posedge pclk);
    pins(4'h7, "balance pin");
    apb(1'b1, TSG_CTRL_OFS, 32'h28);
    repeat (2) @(posedge pclk);
    pins(4'hf, "loop seize pins");
    apb(1'b1, TSG_CTRL_OFS, 32'h8);
    repeat (2) @(posedge pclk);
    pins(4'h7, "loop idle pins");
    end_sim();
  end
  // Watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    end_sim();
  end
endmodule : tb_tsg_ctrl

// ---- testbench/tsg_ctrl_sva.sv ----
// Checker for the ground-start control pin sequence
`timescale 1ns/100ps
module tsg_ctrl_sva
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Trunk pins
  input wire logic tip_ground_detect_n,
  input wire logic ring_ground_detect_n,
  input wire logic line_seize_ctrl,
  input wire logic bias_relay_ctrl,
  input wire logic ring_ground_ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  idle_bias_a: assert property (!line_seize_ctrl |-> bias_relay_ctrl)
    else $error("bias off while line not seized");
  ring_first_a: assert property ($fell(ring_ground_ctrl) |-> bias_relay_ctrl && !line_seize_ctrl)
    else $error("ring grounded outside idle");
  seize_on_tip_a: assert property ($rose(line_seize_ctrl) && !ring_ground_ctrl |-> !$past(tip_ground_detect_n, 2))
    else $error("seize before tip ground");
  seize_then_bias_a: assert property ($rose(line_seize_ctrl) && !ring_ground_ctrl |=> $fell(bias_relay_ctrl))
    else $error("bias not dropped after seize");
  bias_after_seize_a: assert property ($fell(bias_relay_ctrl) |-> line_seize_ctrl
    && ($past(line_seize_ctrl) || ring_ground_ctrl))
    else $error("bias dropped out of order");
  lift_after_bias_a: assert property ($fell(bias_relay_ctrl) |=> ring_ground_ctrl && line_seize_ctrl)
    else $error("ring ground not lifted");
  link_order_a: assert property ($rose(ring_ground_ctrl) && line_seize_ctrl |-> $past(line_seize_ctrl, 2))
    else $error("ring lifted too early");
  incoming_hold_a: assert property (ring_ground_ctrl && !line_seize_ctrl && !ring_ground_detect_n
    |=> ring_ground_ctrl)
    else $error("ring grounded during incoming");
endmodule : tsg_ctrl_sva

bind tsg_ctrl tsg_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn), .tip_ground_detect_n(tip_ground_detect_n),
  .ring_ground_detect_n(ring_ground_detect_n), .line_seize_ctrl(line_seize_ctrl),
  .bias_relay_ctrl(bias_relay_ctrl), .ring_ground_ctrl(ring_ground_ctrl));

// ---- testbench/tsg_trunk_model.sv ----
// Trunk device and central office model
`timescale 1ns/100ps
module tsg_trunk_model #(parameter int RING_DLY = 20, parameter int ANS_DLY = 4)
(
  // Clock
  input wire logic pclk,
  // Control pins
  input wire logic line_seize_ctrl,
  input wire logic bias_relay_ctrl,
  input wire logic ring_ground_ctrl,
  // Office conditions
  input wire logic co_answer,
  input wire logic co_ring_gnd,
  input wire logic co_ringing,
  input wire logic co_batt,
  input wire logic co_rev,
  // Detect pins
  output logic ringing_detect_n,
  output logic forward_loop_detect_n,
  output logic reverse_loop_detect_n,
  output logic tip_ground_detect_n,
  output logic ring_ground_detect_n
);
  logic seize_relay, bias_relay, ring_grounding_relay;
  logic ring_q = 1'b0; // Filtered ringing
  logic tip_q = 1'b0; // Office grounds tip
  int ring_cnt = 0;
  int ans_cnt = 0;
  assign seize_relay = line_seize_ctrl;
  assign bias_relay = bias_relay_ctrl;
  assign ring_grounding_relay = !ring_ground_ctrl;
  ////////////////////////////////////////////////////////////////
  // Office answers a grounded ring after a delay, drops on idle
  always_ff @(posedge pclk)
  begin
    ans_cnt <= (ring_grounding_relay && bias_relay && co_answer) ? ans_cnt + 1 : 0;
    if (ans_cnt == ANS_DLY)
      tip_q <= 1'b1;
    else if (!seize_relay && !ring_grounding_relay)
      tip_q <= 1'b0;
  end
  // Ringing filter follows cadence, not frequency
  always_ff @(posedge pclk)
  begin
    if (co_ringing == ring_q)
      ring_cnt <= 0;
    else if (ring_cnt == RING_DLY - 1)
    begin
      ring_q <= co_ringing;
      ring_cnt <= 0;
    end
    else
      ring_cnt <= ring_cnt + 1;
  end
  assign ringing_detect_n = !ring_q;
  assign forward_loop_detect_n = !(co_batt && !co_rev);
  assign reverse_loop_detect_n = !(co_batt && co_rev);
  assign tip_ground_detect_n = !tip_q;
  assign ring_ground_detect_n = !(ring_grounding_relay || co_ring_gnd);
endmodule : tsg_trunk_model
